// ==== kprc_top.v ====
`timescale 1ns/100ps
`default_nettype none
`include "kprc_defines.vh"
module kprc_top (
  input wire clk_sys_in,
  input wire nrst_in,
  input wire reg_wr_in,
  input wire [7:0] reg_addr_in,
  input wire [7:0] reg_wdata_in,
  output reg [7:0] reg_rdata_out,
  input wire [4:0] scan_int_cfg_in,
  input wire alert_in,
  input wire scan_int_req_in,
  output wire scan_run_out,
  output wire sound_run_out,
  output wire [7:2] port_o_out,
  output wire [7:2] port_oe_n_out,
  output wire int_o_out,
  output wire int_oe_n_out
);

  // ****************************************
  // Registers
  // ****************************************
  reg [7:0] cfg_r;
  reg [7:0] cfg_nxt;
  reg [7:0] rdata_nxt;
  reg int_low;

  // ****************************************
  // Nets
  // ****************************************
  wire [7:1] port_state;
  wire [7:2] port_release;
  wire [7:0] port_word;
  wire run;
  wire cfg_sel;
  wire port_sel;
  wire cfg_wr;
  wire port_wr;
  wire scan_int_off;
  wire int_port_high;
  wire int_rd_bit;

  // ****************************************
  // Functions
  // ****************************************
  // Shared by the write strobes and the readback mux
  function is_cfg_addr;
    input [7:0] addr;
    begin
      is_cfg_addr = (addr == `KPRC_ADDR_CFG);
    end
  endfunction

  function is_port_addr;
    input [7:0] addr;
    begin
      is_port_addr = (addr == `KPRC_ADDR_PORT);
    end
  endfunction

  // All-zero key-scan interrupt field hands the pin to the port register
  function scan_int_disabled;
    input [4:0] field;
    begin
      scan_int_disabled = (field == `KPRC_SCAN_INT_NONE);
    end
  endfunction

  function run_bit;
    input [7:0] cfg;
    begin
      run_bit = cfg[`KPRC_RUN_BIT];
    end
  endfunction

  function [7:2] port_levels;
    input [7:1] state;
    begin
      port_levels = state[`KPRC_PORT_HI:`KPRC_PORT_LO];
    end
  endfunction

  // A released bit reads back as 1
  function [7:0] port_read_word;
    input [7:2] ports;
    input int_high;
    input alert;
    begin
      port_read_word = {ports, int_high, alert};
    end
  endfunction

  // Shutdown keeps key-scan requests off the pin
  function int_pin_low;
    input off;
    input running;
    input request;
    input port_high;
    begin
      if (off) begin
        int_pin_low = ~port_high;
      end else if (running) begin
        int_pin_low = request;
      end else begin
        int_pin_low = 1'h0;
      end
    end
  endfunction

  function [7:0] read_mux;
    input cfg_hit;
    input port_hit;
    input [7:0] cfg_word;
    input [7:0] port_word_in;
    begin
      if (cfg_hit) begin
        read_mux = cfg_word;
      end else if (port_hit) begin
        read_mux = port_word_in;
      end else begin
        read_mux = `KPRC_RDATA_NONE;
      end
    end
  endfunction

  // ****************************************
  // Address decode and write strobes
  // ****************************************
  assign cfg_sel = is_cfg_addr(reg_addr_in);
  assign port_sel = is_port_addr(reg_addr_in);
  assign cfg_wr = reg_wr_in && cfg_sel;
  assign port_wr = reg_wr_in && port_sel;
  assign scan_int_off = scan_int_disabled(scan_int_cfg_in);

  // ****************************************
  // Configuration register
  // ****************************************
  always @* begin
    cfg_nxt = cfg_r;
    if (cfg_wr) begin
      cfg_nxt = reg_wdata_in;
    end
  end

  always @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cfg_r <= `KPRC_CFG_RESET;
    end else begin
      cfg_r <= cfg_nxt;
    end
  end

  // ****************************************
  // Run control
  // ****************************************
  // Scan and sounder engines live outside; they only see these enables
  assign run = run_bit(cfg_r);
  assign scan_run_out = run;
  assign sound_run_out = run;

  // ****************************************
  // Port latch
  // ****************************************
  // Writes land in shutdown as well, so the latch never looks at the run bit
  kprc_port_out u_port (
    .clk_sys_in(clk_sys_in),
    .nrst_in(nrst_in),
    .wr_in(port_wr),
    .wdata_in(reg_wdata_in),
    .scan_int_cfg_in(scan_int_cfg_in),
    .state_out(port_state)
  );

  // ****************************************
  // Port pins
  // ****************************************
  // Data side stays low; only the enables move, so no pin ever drives high
  assign port_release = port_levels(port_state);
  genvar pin_idx;
  generate
    for (pin_idx = `KPRC_PORT_LO; pin_idx <= `KPRC_PORT_HI; pin_idx = pin_idx + 1) begin : g_pin
      assign port_o_out[pin_idx] = `KPRC_PIN_LOW;
      assign port_oe_n_out[pin_idx] = port_release[pin_idx];
    end
  endgenerate

  // ****************************************
  // Interrupt pin
  // ****************************************
  assign int_port_high = port_state[`KPRC_INT_BIT];
  assign int_o_out = `KPRC_PIN_LOW;

  always @* begin
    int_low = int_pin_low(scan_int_off, run, scan_int_req_in, int_port_high);
  end

  assign int_oe_n_out = ~int_low;
  // Reads show the pin as it stands, not the value last written
  assign int_rd_bit = ~int_low;

  // ****************************************
  // Readback
  // ****************************************
  assign port_word = port_read_word(port_release, int_rd_bit, alert_in);

  // Registered: data follows the address by one edge
  always @* begin
    rdata_nxt = read_mux(cfg_sel, port_sel, cfg_r, port_word);
  end

  always @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      reg_rdata_out <= `KPRC_RDATA_RESET;
    end else begin
      reg_rdata_out <= rdata_nxt;
    end
  end
endmodule
`default_nettype wire

// ==== kprc_defines.vh ====
// Functional notes
// - Run bit low stops scan, sounder, interrupts
// - Shutdown still reads alert, writes ports
// - Run bit high starts scan and sounder
// - Port bits 7..2: 0 drives low, 1 releases
// - Bit 1 drives int pin if scan-int off
// - Port read bit 0 returns alert level
`ifndef KPRC_DEFINES_VH
`define KPRC_DEFINES_VH
// ****************************************
// Register map
// ****************************************
`define KPRC_ADDR_CFG 8'h04
`define KPRC_ADDR_PORT 8'h05
`define KPRC_CFG_RESET 8'h01
`define KPRC_PORT_RESET 7'h7f
`define KPRC_RUN_BIT 7
`define KPRC_ALERT_BIT 0
`define KPRC_INT_BIT 1
`define KPRC_SCAN_INT_NONE 5'h00
`define KPRC_PORT_HI 7
`define KPRC_PORT_LO 2
`define KPRC_RDATA_RESET 8'h00
`define KPRC_RDATA_NONE 8'h00
`define KPRC_PIN_LOW 1'h0
`endif

// ==== kprc_port_out.v ====
`timescale 1ns/100ps
`default_nettype none
`include "kprc_defines.vh"
module kprc_port_out (
  input wire clk_sys_in,
  input wire nrst_in,
  input wire wr_in,
  input wire [7:0] wdata_in,
  input wire [4:0] scan_int_cfg_in,
  output reg [7:1] state_out
);
  // ****************************************
  // Port latch; works regardless of run bit
  // ****************************************
  always @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_out <= `KPRC_PORT_RESET;
    end else if (wr_in) begin
      state_out[`KPRC_PORT_HI:`KPRC_PORT_LO] <= wdata_in[`KPRC_PORT_HI:`KPRC_PORT_LO];
      // Int pin only owned here while key-scan interrupts are off
      if (scan_int_cfg_in == `KPRC_SCAN_INT_NONE) begin
        state_out[`KPRC_INT_BIT] <= wdata_in[`KPRC_INT_BIT];
      end
    end
  end
endmodule
`default_nettype wire

// ==== kprc_checker.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "kprc_defines.vh"
module kprc_chk (
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  input wire logic reg_wr_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic [4:0] scan_int_cfg_in,
  input wire logic alert_in,
  input wire logic scan_int_req_in,
  input wire logic scan_run_out,
  input wire logic [7:2] port_oe_n_out,
  input wire logic int_oe_n_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!nrst_in);
  property p_run;
    reg_wr_in && reg_addr_in == `KPRC_ADDR_CFG
      |=> scan_run_out == $past(reg_wdata_in[`KPRC_RUN_BIT]);
  endproperty
  a_run: assert property (p_run) else $error("run bit mismatch");
  property p_port;
    reg_wr_in && reg_addr_in == `KPRC_ADDR_PORT |=> port_oe_n_out == $past(reg_wdata_in[7:2]);
  endproperty
  a_port: assert property (p_port) else $error("port mismatch");
  property p_alert;
    reg_addr_in == `KPRC_ADDR_PORT |=> reg_rdata_out[0] == $past(alert_in);
  endproperty
  a_alert: assert property (p_alert) else $error("alert read mismatch");
  property p_rb;
    reg_addr_in == `KPRC_ADDR_PORT && !reg_wr_in |=> reg_rdata_out[7:2] == $past(port_oe_n_out);
  endproperty
  a_rb: assert property (p_rb) else $error("readback mismatch");
  property p_shut;
    scan_int_cfg_in != `KPRC_SCAN_INT_NONE && !scan_run_out |-> int_oe_n_out;
  endproperty
  a_shut: assert property (p_shut) else $error("interrupt in shutdown");
  property p_intrun;
    scan_int_cfg_in != `KPRC_SCAN_INT_NONE && scan_run_out |-> int_oe_n_out == !scan_int_req_in;
  endproperty
  a_intrun: assert property (p_intrun) else $error("key-scan interrupt pin mismatch");
  property p_intgpo;
    (reg_wr_in && reg_addr_in == `KPRC_ADDR_PORT && scan_int_cfg_in == `KPRC_SCAN_INT_NONE)
      ##1 (scan_int_cfg_in == `KPRC_SCAN_INT_NONE)
      |-> int_oe_n_out == $past(reg_wdata_in[`KPRC_INT_BIT]);
  endproperty
  a_intgpo: assert property (p_intgpo) else $error("int port write mismatch");
  c_port: cover property (reg_wr_in && reg_addr_in == `KPRC_ADDR_PORT);
  c_run: cover property (reg_wr_in && reg_addr_in == `KPRC_ADDR_CFG);
  c_int: cover property (reg_wr_in && scan_int_cfg_in != `KPRC_SCAN_INT_NONE);
endmodule
bind kprc_top kprc_chk u_chk(.*);
`default_nettype wire

// ==== kprc_host.sv ====
`timescale 1ns/100ps
`default_nettype none
module kprc_host(input wire clk_in, output reg wr_out = 0, output reg [7:0] addr_out = 0,
  output reg [7:0] data_out = 0);
  task wr(input [7:0] a, input [7:0] d);
    @(posedge clk_in) #1 {wr_out, addr_out, data_out} = {1'b1, a, d};
    @(posedge clk_in) #1 wr_out = 0;
  endtask
  task sel(input [7:0] a);
    @(posedge clk_in) #1 addr_out = a;
  endtask
endmodule
`default_nettype wire

// ==== testbench.sv ====
`timescale 1ns/100ps
`default_nettype none
module testbench;
  reg clk_sys_in = 0, nrst_in = 0, alert_in = 1, req = 0;
  reg [4:0] cfg = 0;
  wire wr, run, snd, io, io_d;
  wire [7:0] a, d, rd;
  wire [7:2] oe, po;
  integer miscompares = 0, n_tests = 0, cyc = 0;
  always #20 clk_sys_in = ~clk_sys_in;
  kprc_host h(.clk_in(clk_sys_in), .wr_out(wr), .addr_out(a), .data_out(d));
  kprc_top dut(.clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .reg_wr_in(wr), .reg_addr_in(a),
    .reg_wdata_in(d), .reg_rdata_out(rd), .scan_int_cfg_in(cfg), .alert_in(alert_in),
    .scan_int_req_in(req), .scan_run_out(run), .sound_run_out(snd), .port_o_out(po),
    .port_oe_n_out(oe), .int_o_out(io_d), .int_oe_n_out(io));
  task cmp(input [8*8:1] n, input [7:0] e, input [7:0] s);
    n_tests++;
    if (s !== e) begin
      miscompares++;
      $display("[FAIL] %0s exp %h got %h", n, e, s);
    end
  endtask
  task stop_test;
    $display("mismatches %0d checks %0d", miscompares, n_tests);
    if (miscompares == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge clk_sys_in) if (++cyc > 2000) begin miscompares++; stop_test; end
  task t_idle;
    cmp("oe", 8'h3f, oe);
    cmp("int", 8'h01, io);
    cmp("run", 8'h00, run);
    cmp("sound", 8'h00, snd);
    cmp("rd", 8'h00, rd);
  endtask
  task t_reset;
    t_idle;
    cmp("pdat", 8'h00, po);
    cmp("idat", 8'h00, io_d);
    h.sel(8'h04);
    @(posedge clk_sys_in) #1 cmp("cfg", 8'h01, rd);
    h.sel(8'h05);
    @(posedge clk_sys_in) #1 cmp("read", 8'hFF, rd);
  endtask
  task t_port;
    h.wr(8'h05, 8'hA9);
    cmp("port", 8'h2a, oe);
    cmp("int", 8'h00, io);
    @(posedge clk_sys_in) #1 cmp("read", 8'hA9, rd);
    alert_in = 1'b0;
    @(posedge clk_sys_in) #1 cmp("alert", 8'hA8, rd);
    alert_in = 1'b1;
  endtask
  task t_intref;
    cfg = 5'h01;
    h.wr(8'h05, 8'hFF);
    cmp("port", 8'h3f, oe);
    cmp("int", 8'h01, io);
    @(posedge clk_sys_in) #1 cmp("read", 8'hFF, rd);
    cfg = 5'h00;
    @(posedge clk_sys_in) #1 cmp("intkeep", 8'h00, io);
  endtask
  task t_run;
    cfg = 5'h01;
    req = 1'b1;
    h.wr(8'h04, 8'h80);
    cmp("run", 8'h01, run);
    cmp("sound", 8'h01, snd);
    cmp("int", 8'h00, io);
    @(posedge clk_sys_in) #1 cmp("cfg", 8'h80, rd);
    h.wr(8'h04, 8'h01);
    cmp("run", 8'h00, run);
    cmp("int", 8'h01, io);
    @(posedge clk_sys_in) #1 cmp("cfg", 8'h01, rd);
    req = 1'b0;
    cfg = 5'h00;
  endtask
  task t_unmapped;
    h.wr(8'h10, 8'h00);
    cmp("port", 8'h3f, oe);
    cmp("int", 8'h00, io);
    @(posedge clk_sys_in) #1 cmp("none", 8'h00, rd);
    h.sel(8'h04);
    @(posedge clk_sys_in) #1 cmp("cfg", 8'h01, rd);
  endtask
  task t_midreset;
    nrst_in = 1'b0;
    @(posedge clk_sys_in) #1 nrst_in = 1'b1;
    t_idle;
    h.sel(8'h05);
    @(posedge clk_sys_in) #1 cmp("read", 8'hFF, rd);
  endtask
  initial begin
    repeat (10) @(posedge clk_sys_in);
    #1 nrst_in = 1;
    t_reset;
    t_port;
    t_intref;
    t_run;
    t_unmapped;
    t_midreset;
    stop_test;
  end
endmodule
`default_nettype wire
